// *** nand_busy_timer.sv ***
// Counts one busy window and flags a timeout
module nand_busy_timer
   import nand_host_pkg::*;
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // Control
   input wire logic start_i,
   input wire logic [TMR_W-1:0] limit_i,
   input wire logic stop_i,
   // Status
   output logic expired_o,
   output logic running_o
);
   logic [TMR_W-1:0] cnt_q, cnt_d;
   logic run_q, run_d;
   logic exp_q, exp_d;

   always_comb
   begin
      cnt_d = cnt_q;
      run_d = run_q;
      exp_d = 1'b0;
      if (start_i)
      begin
         cnt_d = limit_i;
         run_d = 1'b1;
      end
      else if (run_q && stop_i)
      begin
         run_d = 1'b0;
      end
      else if (run_q)
      begin
         if (cnt_q == '0)
         begin
            exp_d = 1'b1;
            run_d = 1'b0;
         end
         else
         begin
            cnt_d = cnt_q - 1'b1;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cnt_q <= '0;
         run_q <= 1'b0;
         exp_q <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_d;
         run_q <= run_d;
         exp_q <= exp_d;
      end
   end

   assign expired_o = exp_q;
   assign running_o = run_q;
endmodule // nand_busy_timer

// *** nand_dev_model.sv ***
module nand_dev_model
   import nand_host_pkg::*;
(
   // Clock and host side
   input wire logic mclk_i,
   input wire logic start_i,
   input wire logic [TMR_W-1:0] busy_cyc_i,
   input wire logic [BLK_W-1:0] mark_block_i,
   // Device answers
   output logic ready_busy_o,
   output logic [7:0] mark_byte_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;
   int len = 0;
   always @(posedge mclk_i)
   begin
      if (start_i)
      begin
         len <= int'(busy_cyc_i);
         cnt <= int'(busy_cyc_i) + 5;
      end
      else if (cnt > 0)
         cnt <= cnt - 1;
   end
   // Pulled-up line reads ready when idle
   assign ready_busy_o = !(cnt > 0 && cnt <= len);
   assign mark_byte_o = (mark_block_i[BLK_W-1:4] == 8'hFF) ? 8'h00 : ERASED_MARK;
endmodule // nand_dev_model

// *** nand_host_pkg.sv ***
package nand_host_pkg;
   localparam int CLK_MHZ = 250;
   // ----------------------------------------------------------------
   // Timing figures
   // ----------------------------------------------------------------
   localparam int WB_WINDOW_NS = 100;
   localparam int READ_BUSY_US = 25;
   localparam int FEAT_BUSY_US = 1;
   localparam int LOCK_BUSY_US = 3;
   localparam int OTP_BUSY_US = 30;
   localparam int DUAL_BUSY_US = 1;
   localparam int WB_CYC = (WB_WINDOW_NS * CLK_MHZ + 999) / 1000;
   localparam int READ_CYC = READ_BUSY_US * CLK_MHZ;
   localparam int FEAT_CYC = FEAT_BUSY_US * CLK_MHZ;
   localparam int LOCK_CYC = LOCK_BUSY_US * CLK_MHZ;
   localparam int OTP_CYC = OTP_BUSY_US * CLK_MHZ;
   localparam int DUAL_CYC = DUAL_BUSY_US * CLK_MHZ;
   localparam int TMR_W = 16;
   // ----------------------------------------------------------------
   // Array geometry and marks
   // ----------------------------------------------------------------
   localparam int BLOCKS = 4096;
   localparam int MIN_VALID_BLOCKS = 4016;
   localparam int BLK_W = 12;
   localparam int PAGE_W = 6;
   localparam int PPC_W = 3;
   localparam logic [PPC_W-1:0] PARTIAL_PROGRAM_LIMIT = 3'h4;
   localparam logic [7:0] ERASED_MARK = 8'hFF;
   localparam logic [BLK_W-1:0] GOOD_BLOCK0 = 12'h000;
   localparam int ECC_SPAN_BYTES = 528;
   // Operation kinds
   typedef enum logic [2:0]
   {
      OP_READ = 3'h0,
      OP_FEATURE = 3'h1,
      OP_PROGRAM = 3'h2,
      OP_ERASE = 3'h3,
      OP_OTP_PROGRAM = 3'h4,
      OP_DUAL_FIRST = 3'h5
   } op_kind_e;
   localparam logic [7:0] STATUS_FAIL_BIT = 8'h01;
endpackage

// *** nand_op_sequencer.sv ***
// Host-side operation sequencer: wait, busy watch, bad-block table
module nand_op_sequencer
   import nand_host_pkg::*;
(
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_b_i,
   // Operation request
   input wire logic op_valid_i,
   input wire logic [2:0] op_kind_i,
   input wire logic [BLK_W-1:0] op_block_i,
   input wire logic [PAGE_W-1:0] op_page_i,
   output logic op_ready_o,
   // Strobe engine handshake
   output logic issue_o,
   input wire logic last_strobe_i,
   // Device pins
   input wire logic ready_busy_i,
   // Status and bad-block scan results
   input wire logic status_valid_i,
   input wire logic [7:0] status_i,
   input wire logic mark_valid_i,
   input wire logic [BLK_W-1:0] mark_block_i,
   input wire logic [7:0] mark_byte_i,
   input wire logic scan_done_i,
   // Outcome
   output logic done_o,
   output logic fail_o,
   output logic timeout_o,
   output logic refused_o,
   output logic retire_o,
   output logic [BLK_W-1:0] retire_block_o
);
   // ----------------------------------------------------------------
   // Reset and pin synchronisers
   // ----------------------------------------------------------------
   logic rst_s1_q, rst_n;
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         rst_s1_q <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_s1_q <= 1'b1;
         rst_n <= rst_s1_q;
      end
   end

   logic rb_s1_q, rb_s2_q;
   always_ff @(posedge mclk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         // Pulled-up line idles ready
         rb_s1_q <= 1'b1;
         rb_s2_q <= 1'b1;
      end
      else
      begin
         rb_s1_q <= ready_busy_i;
         rb_s2_q <= rb_s1_q;
      end
   end

   // ----------------------------------------------------------------
   // Bad-block table and page tracking
   // ----------------------------------------------------------------
   logic bad_q [BLOCKS];
   logic [PAGE_W-1:0] next_page_q [BLOCKS];
   logic [PPC_W-1:0] pp_cnt_q [BLOCKS];
   logic started_q [BLOCKS];

   typedef enum logic [5:0]
   {
      S_SCAN = 6'b000001,
      S_IDLE = 6'b000010,
      S_ISSUE = 6'b000100,
      S_WB = 6'b001000,
      S_BUSY = 6'b010000,
      S_STATUS = 6'b100000
   } state_e;

   state_e st_q, st_d;
   logic [2:0] kind_q, kind_d;
   logic [BLK_W-1:0] blk_q, blk_d;
   logic [PAGE_W-1:0] page_q, page_d;
   logic [TMR_W-1:0] wb_q, wb_d;
   logic done_q, done_d, fail_q, fail_d, to_q, to_d, ref_q, ref_d;
   logic ret_q, ret_d;
   logic tmr_start, tmr_exp;
   logic [TMR_W-1:0] tmr_lim;

   function automatic logic [TMR_W-1:0] busy_limit(input logic [2:0] k);
      unique case (k)
         OP_READ: busy_limit = TMR_W'(READ_CYC);
         OP_FEATURE: busy_limit = TMR_W'(FEAT_CYC);
         OP_OTP_PROGRAM: busy_limit = TMR_W'(OTP_CYC);
         OP_DUAL_FIRST: busy_limit = TMR_W'(DUAL_CYC);
         // Program/erase limits are long; all-ones maximum count used as the bound
         default: busy_limit = '1;
      endcase
   endfunction

   function automatic logic is_write(input logic [2:0] k);
      is_write = (k == OP_PROGRAM) || (k == OP_ERASE) || (k == OP_OTP_PROGRAM);
   endfunction

   logic page_ok;
   always_comb
   begin
      page_ok = !started_q[op_block_i] || (op_page_i >= next_page_q[op_block_i]);
      if (op_kind_i == OP_PROGRAM && started_q[op_block_i]
          && op_page_i == next_page_q[op_block_i] - 1'b1)
         page_ok = pp_cnt_q[op_block_i] < PARTIAL_PROGRAM_LIMIT;
   end

   always_comb
   begin
      st_d = st_q;
      kind_d = kind_q;
      blk_d = blk_q;
      page_d = page_q;
      wb_d = wb_q;
      done_d = 1'b0;
      fail_d = 1'b0;
      to_d = 1'b0;
      ref_d = 1'b0;
      ret_d = 1'b0;
      tmr_start = 1'b0;
      tmr_lim = busy_limit(kind_q);
      unique case (st_q)
         S_SCAN:
            if (scan_done_i)
               st_d = S_IDLE;
         S_IDLE:
            if (op_valid_i)
            begin
               // block zero never refused as bad
               if (is_write(op_kind_i) && ((bad_q[op_block_i] && op_block_i != GOOD_BLOCK0)
                   || (op_kind_i == OP_PROGRAM && !page_ok)))
                  ref_d = 1'b1;
               else
               begin
                  kind_d = op_kind_i;
                  blk_d = op_block_i;
                  page_d = op_page_i;
                  st_d = S_ISSUE;
               end
            end
         S_ISSUE:
            if (last_strobe_i)
            begin
               wb_d = TMR_W'(WB_CYC);
               st_d = S_WB;
            end
         S_WB:
            if (wb_q == '0)
            begin
               tmr_start = 1'b1;
               st_d = S_BUSY;
            end
            else
               wb_d = wb_q - 1'b1;
         S_BUSY:
            if (rb_s2_q && !tmr_start)
               st_d = is_write(kind_q) ? S_STATUS : S_IDLE;
            else if (tmr_exp)
            begin
               to_d = 1'b1;
               st_d = S_IDLE;
            end
         S_STATUS:
            if (status_valid_i)
            begin
               fail_d = (status_i & STATUS_FAIL_BIT) != 8'h00;
               ret_d = fail_d && kind_q != OP_OTP_PROGRAM;
               st_d = S_IDLE;
            end
         default: st_d = S_IDLE;
      endcase
      done_d = (st_q == S_BUSY && st_d == S_IDLE && !to_d) || (st_q == S_STATUS && st_d == S_IDLE);
   end

   always_ff @(posedge mclk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_q <= S_SCAN;
         kind_q <= 3'h0;
         blk_q <= '0;
         page_q <= '0;
         wb_q <= '0;
         done_q <= 1'b0;
         fail_q <= 1'b0;
         to_q <= 1'b0;
         ref_q <= 1'b0;
         ret_q <= 1'b0;
      end
      else
      begin
         st_q <= st_d;
         kind_q <= kind_d;
         blk_q <= blk_d;
         page_q <= page_d;
         wb_q <= wb_d;
         done_q <= done_d;
         fail_q <= fail_d;
         to_q <= to_d;
         ref_q <= ref_d;
         ret_q <= ret_d;
      end
   end

   // Tables have no reset: scan state gates their use
   always_ff @(posedge mclk_i)
   begin
      // non-FFh mark means bad
      // Good marks clear the entry too, so no block stays unknown
      if (st_q == S_SCAN && mark_valid_i)
         bad_q[mark_block_i] <= (mark_byte_i != ERASED_MARK);
      if (st_q == S_SCAN && mark_valid_i)
         started_q[mark_block_i] <= 1'b0;
      if (ret_d)
         bad_q[blk_q] <= 1'b1;
      if (st_q == S_STATUS && status_valid_i && kind_q == OP_ERASE)
      begin
         started_q[blk_q] <= 1'b0;
         pp_cnt_q[blk_q] <= '0;
      end
      if (st_q == S_IDLE && st_d == S_ISSUE && op_kind_i == OP_PROGRAM)
      begin
         started_q[op_block_i] <= 1'b1;
         next_page_q[op_block_i] <= op_page_i + 1'b1;
         if (started_q[op_block_i] && op_page_i == next_page_q[op_block_i] - 1'b1)
            pp_cnt_q[op_block_i] <= pp_cnt_q[op_block_i] + 1'b1;
         else
            pp_cnt_q[op_block_i] <= 3'h1;
      end
   end

   nand_busy_timer u_timer
   (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n),
      .start_i(tmr_start),
      .limit_i(tmr_lim),
      .stop_i(rb_s2_q),
      .expired_o(tmr_exp),
      .running_o()
   );

   assign op_ready_o = (st_q == S_IDLE);
   assign issue_o = (st_q == S_ISSUE);
   assign done_o = done_q;
   assign fail_o = fail_q;
   assign timeout_o = to_q;
   assign refused_o = ref_q;
   assign retire_o = ret_q;
   assign retire_block_o = blk_q;
endmodule // nand_op_sequencer

// *** nand_op_sequencer_tb_top.sv ***
module nand_op_sequencer_tb_top
   import nand_host_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk_i = 1'h0, rst_b_i = 1'h0, op_valid_i = 1'h0, last_strobe_i = 1'h0;
   logic status_valid_i = 1'h0, mark_valid_i = 1'h0, scan_done_i = 1'h0;
   logic [2:0] op_kind_i = 3'h0;
   logic [BLK_W-1:0] op_block_i = 12'h000, mark_block_i = 12'h000, retire_block_o;
   logic [PAGE_W-1:0] op_page_i = 6'h00;
   logic [7:0] status_i = 8'h00, mark_byte_i;
   logic [TMR_W-1:0] busy_cyc = 16'h0000;
   logic ready_busy_i, op_ready_o, issue_o, done_o, fail_o, timeout_o, refused_o, retire_o;
   int error_cnt = 0;
   int checks = 0;
   always #2 mclk_i = ~mclk_i;
   nand_op_sequencer dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .op_valid_i(op_valid_i),
      .op_kind_i(op_kind_i), .op_block_i(op_block_i), .op_page_i(op_page_i),
      .op_ready_o(op_ready_o), .issue_o(issue_o), .last_strobe_i(last_strobe_i),
      .ready_busy_i(ready_busy_i), .status_valid_i(status_valid_i), .status_i(status_i),
      .mark_valid_i(mark_valid_i), .mark_block_i(mark_block_i), .mark_byte_i(mark_byte_i),
      .scan_done_i(scan_done_i), .done_o(done_o), .fail_o(fail_o), .timeout_o(timeout_o),
      .refused_o(refused_o), .retire_o(retire_o), .retire_block_o(retire_block_o));
   nand_dev_model u_dev (.mclk_i(mclk_i), .start_i(last_strobe_i), .busy_cyc_i(busy_cyc),
      .mark_block_i(mark_block_i), .ready_busy_o(ready_busy_i), .mark_byte_o(mark_byte_i));
   task automatic finish_test();
      $display("errors %0d checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk_b(input string nm, input logic e, input logic g);
      checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("BAD %s exp %b got %b", nm, e, g);
      end
   endtask
   task automatic chk_w(input string nm, input logic [BLK_W-1:0] e, input logic [BLK_W-1:0] g);
      checks++;
      if (g !== e)
      begin
         error_cnt++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   // One operation; waits for idle and device ready first
   task automatic do_op(input logic [2:0] k, input int b, input int p, input int bc,
      input logic [7:0] st, input logic eref, input logic eto);
      int n;
      logic r, d, t, f;
      n = 0;
      while ((op_ready_o !== 1'h1 || ready_busy_i !== 1'h1) && n < 400)
      begin
         @(negedge mclk_i);
         n++;
      end
      chk_b("ready_wait", 1'h1, op_ready_o);
      op_valid_i = 1'h1;
      op_kind_i = k;
      op_block_i = b[BLK_W-1:0];
      op_page_i = p[PAGE_W-1:0];
      busy_cyc = bc[TMR_W-1:0];
      @(negedge mclk_i);
      op_valid_i = 1'h0;
      r = refused_o;
      @(negedge mclk_i);
      r = r | refused_o;
      chk_b("refused", eref, r);
      if (eref)
         return;
      chk_b("issue", 1'h1, issue_o);
      last_strobe_i = 1'h1;
      @(negedge mclk_i);
      last_strobe_i = 1'h0;
      d = 1'h0;
      t = 1'h0;
      f = 1'h0;
      for (n = 0; n < bc + 300 && d !== 1'h1 && t !== 1'h1; n++)
      begin
         @(negedge mclk_i);
         status_valid_i = (n == bc + 40);
         status_i = st;
         d = done_o;
         t = timeout_o;
         f = fail_o;
      end
      status_valid_i = 1'h0;
      chk_b("timeout", eto, t);
      chk_b("done", !eto, d);
      chk_b("fail", st[0], f);
      if (st[0])
         chk_w("retire_blk", b[BLK_W-1:0], retire_block_o);
   endtask
   task automatic t_scan();
      for (int i = 0; i < BLOCKS; i++)
      begin
         @(negedge mclk_i);
         mark_valid_i = 1'h1;
         mark_block_i = i[BLK_W-1:0];
      end
      @(negedge mclk_i);
      mark_valid_i = 1'h0;
      chk_b("ready_in_scan", 1'h0, op_ready_o);
      scan_done_i = 1'h1;
      @(negedge mclk_i);
      scan_done_i = 1'h0;
      repeat (3) @(negedge mclk_i);
      chk_b("ready_after_scan", 1'h1, op_ready_o);
   endtask
   task automatic t_kinds();
      for (int k = 0; k < 6; k++)
         do_op(k[2:0], 16 + k, 0, 100, 8'h00, 1'h0, 1'h0);
      do_op(OP_READ, 1, 0, 6400, 8'h00, 1'h0, 1'h1);
   endtask
   task automatic t_order();
      do_op(OP_PROGRAM, 5, 3, 100, 8'h00, 1'h0, 1'h0);
      do_op(OP_PROGRAM, 5, 2, 100, 8'h00, 1'h1, 1'h0);
      do_op(OP_PROGRAM, 5, 4, 100, 8'h00, 1'h0, 1'h0);
   endtask
   task automatic t_partial();
      for (int i = 0; i < 4; i++)
         do_op(OP_PROGRAM, 6, 0, 100, 8'h00, 1'h0, 1'h0);
      do_op(OP_PROGRAM, 6, 0, 100, 8'h00, 1'h1, 1'h0);
   endtask
   task automatic t_table();
      do_op(OP_PROGRAM, 4090, 0, 100, 8'h00, 1'h1, 1'h0);
      do_op(OP_ERASE, 0, 0, 100, 8'h00, 1'h0, 1'h0);
      do_op(OP_ERASE, 7, 0, 100, 8'h01, 1'h0, 1'h0);
   endtask
   initial
   begin
      repeat (8) @(negedge mclk_i);
      rst_b_i = 1'h1;
      repeat (4) @(negedge mclk_i);
      t_scan();
      t_kinds();
      t_order();
      t_partial();
      t_table();
      finish_test();
   end
   initial
   begin
      #200000;
      error_cnt++;
      finish_test();
   end
endmodule // nand_op_sequencer_tb_top

// *** nand_seq_checker.sv ***
module nand_seq_checker
   import nand_host_pkg::*;
(
   // Watched ports
   input wire logic mclk_i,
   input wire logic rst_b_i,
   input wire logic op_valid_i,
   input wire logic op_ready_o,
   input wire logic issue_o,
   input wire logic last_strobe_i,
   input wire logic ready_busy_i,
   input wire logic status_valid_i,
   input wire logic [7:0] status_i,
   input wire logic scan_done_i,
   input wire logic done_o,
   input wire logic fail_o,
   input wire logic retire_o,
   input wire logic refused_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic scan_q;
   logic scan_d;
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);
   always_comb scan_d = scan_q | scan_done_i;
   always_ff @(posedge mclk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         scan_q <= 1'h0;
      else
         scan_q <= scan_d;
   end
   sequence s_taken;
      op_valid_i && op_ready_o;
   endsequence
   // Four low samples cover the two-flop sync
   sequence s_busy;
      !ready_busy_i [*4];
   endsequence
   sequence s_stat(bad);
      status_valid_i && status_i[0] == bad;
   endsequence
   property p_scan_first;
      !scan_q |-> !op_ready_o;
   endproperty
   a_scan_first: assert property (p_scan_first) else $error("idle before scan");
   property p_take;
      s_taken |-> ##[1:2] (issue_o || refused_o);
   endproperty
   a_take: assert property (p_take) else $error("request lost");
   property p_refuse;
      refused_o |-> !issue_o ##1 !issue_o;
   endproperty
   a_refuse: assert property (p_refuse) else $error("refused op issued");
   // Eight quiet cycles; chained to span the whole window
   sequence s_quiet;
      (!op_ready_o && !issue_o) [*8];
   endsequence
   // Window is 25 cycles at this clock
   property p_wb_gap;
      last_strobe_i && issue_o |=> s_quiet ##1 s_quiet ##1 s_quiet ##1 (!op_ready_o && !issue_o);
   endproperty
   a_wb_gap: assert property (p_wb_gap) else $error("command in busy window");
   property p_busy_hold;
      s_busy |-> !done_o;
   endproperty
   a_busy_hold: assert property (p_busy_hold) else $error("done while busy");
   property p_fail;
      s_stat(1'h1) |=> done_o && fail_o && retire_o;
   endproperty
   a_fail: assert property (p_fail) else $error("failure not retired");
   property p_pass;
      s_stat(1'h0) |=> done_o && !fail_o && !retire_o;
   endproperty
   a_pass: assert property (p_pass) else $error("pass misreported");
endmodule // nand_seq_checker

bind nand_op_sequencer nand_seq_checker u_chk (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
   .op_valid_i(op_valid_i), .op_ready_o(op_ready_o), .issue_o(issue_o),
   .last_strobe_i(last_strobe_i), .ready_busy_i(ready_busy_i),
   .status_valid_i(status_valid_i), .status_i(status_i), .scan_done_i(scan_done_i),
   .done_o(done_o), .fail_o(fail_o), .retire_o(retire_o), .refused_o(refused_o));
